//--- general_purpose_timer_unit.sv
`timescale 1ns/1ps

module general_purpose_timer_unit #(
	parameter int TMR_W = timer_unit_pkg::TMR_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Gate/clock and direction pins, one per timer
	input wire logic [timer_unit_pkg::NUM_TMR-1:0] timer_gate_clock_input,
	input wire logic [timer_unit_pkg::NUM_TMR-1:0] timer_direction_input,
	// Capture pin of module two
	input wire logic capture_trigger_input,
	// Configuration
	input timer_unit_pkg::timer_cfg_s tmr_cfg [timer_unit_pkg::NUM_TMR],
	input timer_unit_pkg::aux_cfg_s aux_cfg [2],
	input timer_unit_pkg::mod2_cfg_s mod2_cfg,
	// Software loads
	input wire logic [timer_unit_pkg::NUM_TMR-1:0] tmr_wr,
	input wire logic capture_reload_reg_wr,
	input wire logic [TMR_W-1:0] wr_data,
	// Timer state
	output logic [TMR_W-1:0] tmr_val [timer_unit_pkg::NUM_TMR],
	output logic [TMR_W-1:0] capture_reload_reg,
	output logic [timer_unit_pkg::NUM_TMR-1:0] wrap_evt_r,
	output logic capture_evt_r,
	// Toggle latches
	output logic core_toggle_latch,
	output logic core_toggle_output_pin,
	output logic toggle_two_latch
);

	// Short local names for package figures
	localparam int NT = timer_unit_pkg::NUM_TMR;
	localparam int NP = timer_unit_pkg::NUM_PIN;
	localparam int PW = timer_unit_pkg::PRESC_W;
	// Aux timers of module one, by aux config slot
	localparam int AUX_IX [2] = '{timer_unit_pkg::IX_A, timer_unit_pkg::IX_B};

	// The package types carry a fixed 16-bit layout
	if (TMR_W != timer_unit_pkg::TMR_W) begin : g_chk
		$error("general_purpose_timer_unit: TMR_W must match the package width");
	end

	// Reset release synchroniser
	logic [1:0] rst_sync_r;
	// Reset used by the whole design
	logic rst_q_n;
	// Free-running prescaler divider
	logic [PW-1:0] div_r;
	// Pin synchronisers, filtered levels and edges
	logic [2:0] pin_sync_r [NP];
	logic [NP-1:0] pin_lvl_r;
	logic [NP-1:0] pin_rise_r;
	logic [NP-1:0] pin_fall_r;
	// All pins in one vector
	logic [NP-1:0] pins_all;
	// Per-timer cell controls
	logic [NT-1:0] pre_tick;
	logic [NT-1:0] alt_evt;
	logic [NT-1:0] stop;
	logic [NT-1:0] ld;
	logic [TMR_W-1:0] ld_val [NT];
	// Per-timer cell results
	logic [TMR_W-1:0] cnt [NT];
	logic [NT-1:0] ovf;
	logic [NT-1:0] unf;
	// Toggle latches and their transitions
	logic tl1_r;
	logic tl2_r;
	logic tl1_chg;
	logic tl1_rise;
	logic tl1_fall;
	logic tl2_chg;
	// Module-two capture event
	logic cap_evt;
	// Capture/reload register
	logic [TMR_W-1:0] capture_reload_reg_r;

	// Prescaler tap: true once every PRESC_BASE << sel clocks
	function automatic logic presc_tick(input logic [PW-1:0] dc,
		input logic [timer_unit_pkg::PSEL_W-1:0] sel);
		logic [PW-1:0] mask;
		mask = PW'((timer_unit_pkg::PRESC_BASE << sel) - 1);
		return (dc & mask) == mask;
	endfunction : presc_tick

	// Reload trigger decode for one aux timer
	function automatic logic rld_hit(input timer_unit_pkg::aux_cfg_s ac,
		input logic pr, input logic pf, input logic tr, input logic tf);
		logic hit;
		hit = 1'b0;
		case (ac.rld_src)
			timer_unit_pkg::RLD_PIN: begin
				hit = timer_unit_pkg::edge_hit(ac.edge_sel, pr, pf);
			end
			timer_unit_pkg::RLD_TL_RISE: begin
				hit = tr;
			end
			timer_unit_pkg::RLD_TL_FALL: begin
				hit = tf;
			end
			timer_unit_pkg::RLD_TL_ANY: begin
				hit = tr | tf;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
		return (ac.fn == timer_unit_pkg::AUX_RELOAD) & hit;
	endfunction : rld_hit

	// Reset: asynchronous assert, release after two clocks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	assign rst_q_n = rst_sync_r[1];

	// Prescaler divider shared by all timers
	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 1'b1;
		end
	end

	assign pins_all = {capture_trigger_input, timer_direction_input, timer_gate_clock_input};

	// Pin synchronisers; a level counts once stages two and three agree
	for (genvar p = 0; p < NP; p++) begin : g_pin
		always_ff @(posedge clk or negedge rst_q_n) begin
			if (!rst_q_n) begin
				pin_sync_r[p] <= 3'h0;
				pin_lvl_r[p] <= 1'b0;
				pin_rise_r[p] <= 1'b0;
				pin_fall_r[p] <= 1'b0;
			end else begin
				pin_sync_r[p] <= {pin_sync_r[p][1:0], pins_all[p]};
				// Stage one is read only by stage two
				if (pin_sync_r[p][1] == pin_sync_r[p][2]) begin
					pin_lvl_r[p] <= pin_sync_r[p][2];
					pin_rise_r[p] <= pin_sync_r[p][2] & ~pin_lvl_r[p];
					pin_fall_r[p] <= ~pin_sync_r[p][2] & pin_lvl_r[p];
				end else begin
					pin_rise_r[p] <= 1'b0;
					pin_fall_r[p] <= 1'b0;
				end
			end
		end
	end

	// Toggle latch transitions happen in the cycle of the wrap
	// toggle on each wrap
	assign tl1_chg = ovf[timer_unit_pkg::IX_CORE1] | unf[timer_unit_pkg::IX_CORE1];
	assign tl1_rise = tl1_chg & ~tl1_r;
	assign tl1_fall = tl1_chg & tl1_r;
	assign tl2_chg = ovf[timer_unit_pkg::IX_CORE2] | unf[timer_unit_pkg::IX_CORE2];

	// Module-two capture trigger select
	always_comb begin
		if (mod2_cfg.cap_src == timer_unit_pkg::CAP_SRC_PIN) begin
			cap_evt = timer_unit_pkg::edge_hit(mod2_cfg.cap_edge,
				pin_rise_r[timer_unit_pkg::IX_CAP], pin_fall_r[timer_unit_pkg::IX_CAP]);
		end else begin
			cap_evt = (mod2_cfg.cap_src[0] &
				(pin_rise_r[timer_unit_pkg::IX_CORE1] | pin_fall_r[timer_unit_pkg::IX_CORE1])) |
				(mod2_cfg.cap_src[1] &
				(pin_rise_r[timer_unit_pkg::IX_DIR0 + timer_unit_pkg::IX_CORE1] |
				pin_fall_r[timer_unit_pkg::IX_DIR0 + timer_unit_pkg::IX_CORE1]));
		end
	end

	// Per-timer controls: loads, stops and alternate clocks
	always_comb begin
		// Defaults: software write loads, nothing stopped
		for (int i = 0; i < NT; i++) begin
			pre_tick[i] = presc_tick(div_r, tmr_cfg[i].presc);
			ld[i] = tmr_wr[i];
			ld_val[i] = wr_data;
			stop[i] = 1'b0;
			alt_evt[i] = 1'b0;
		end
		// Aux a and aux b of module one
		for (int k = 0; k < 2; k++) begin
			stop[AUX_IX[k]] = aux_cfg[k].fn != timer_unit_pkg::AUX_COUNT;
			// latch clocks aux; concatenation with core
			alt_evt[AUX_IX[k]] = tl1_chg;
			if ((aux_cfg[k].fn == timer_unit_pkg::AUX_CAPTURE) &&
				timer_unit_pkg::edge_hit(aux_cfg[k].edge_sel,
				pin_rise_r[AUX_IX[k]], pin_fall_r[AUX_IX[k]])) begin
				ld[AUX_IX[k]] = 1'b1;
				ld_val[AUX_IX[k]] = cnt[timer_unit_pkg::IX_CORE1];
			end
		end
		// reload core; aux a wins a tie
		if (rld_hit(aux_cfg[1], pin_rise_r[timer_unit_pkg::IX_B],
			pin_fall_r[timer_unit_pkg::IX_B], tl1_rise, tl1_fall)) begin
			ld[timer_unit_pkg::IX_CORE1] = 1'b1;
			ld_val[timer_unit_pkg::IX_CORE1] = cnt[timer_unit_pkg::IX_B];
		end
		if (rld_hit(aux_cfg[0], pin_rise_r[timer_unit_pkg::IX_A],
			pin_fall_r[timer_unit_pkg::IX_A], tl1_rise, tl1_fall)) begin
			ld[timer_unit_pkg::IX_CORE1] = 1'b1;
			ld_val[timer_unit_pkg::IX_CORE1] = cnt[timer_unit_pkg::IX_A];
		end
		alt_evt[timer_unit_pkg::IX_C] = tl2_chg;
		if (cap_evt && mod2_cfg.clr_c) begin
			ld[timer_unit_pkg::IX_C] = 1'b1;
			ld_val[timer_unit_pkg::IX_C] = '0;
		end
		if (mod2_cfg.rel_en && tl2_chg) begin
			ld[timer_unit_pkg::IX_CORE2] = 1'b1;
			ld_val[timer_unit_pkg::IX_CORE2] = capture_reload_reg_r;
		end
	end

	// five timer cells; per-timer mode; a gate/clock pin and a direction pin each
	for (genvar t = 0; t < NT; t++) begin : g_tmr
		timer_cell #(
			.W(TMR_W)
		) u_cell (
			.clk(clk),
			.rst_n(rst_q_n),
			.cfg(tmr_cfg[t]),
			.pre_tick(pre_tick[t]),
			.in_lvl(pin_lvl_r[t]),
			.in_rise(pin_rise_r[t]),
			.in_fall(pin_fall_r[t]),
			.eud_lvl(pin_lvl_r[timer_unit_pkg::IX_DIR0 + t]),
			.eud_chg(pin_rise_r[timer_unit_pkg::IX_DIR0 + t] |
				pin_fall_r[timer_unit_pkg::IX_DIR0 + t]),
			.alt_evt(alt_evt[t]),
			.stop(stop[t]),
			.ld(ld[t]),
			.ld_val(ld_val[t]),
			.cnt_r(cnt[t]),
			.ovf(ovf[t]),
			.unf(unf[t])
		);
		assign tmr_val[t] = cnt[t];
	end

	// Toggle latches
	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			tl1_r <= 1'b0;
			tl2_r <= 1'b0;
		end else begin
			if (tl1_chg) begin
				tl1_r <= ~tl1_r;
			end
			if (tl2_chg) begin
				tl2_r <= ~tl2_r;
			end
		end
	end

	// latch state on the output pin
	assign core_toggle_latch = tl1_r;
	assign core_toggle_output_pin = tl1_r;
	assign toggle_two_latch = tl2_r;

	// Capture/reload register; a capture beats a software write
	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			capture_reload_reg_r <= '0;
		end else if (cap_evt) begin
			capture_reload_reg_r <= cnt[timer_unit_pkg::IX_C];
		end else if (capture_reload_reg_wr) begin
			capture_reload_reg_r <= wr_data;
		end
	end

	assign capture_reload_reg = capture_reload_reg_r;

	// Event strobes, one clock after the cause
	always_ff @(posedge clk or negedge rst_q_n) begin
		if (!rst_q_n) begin
			wrap_evt_r <= '0;
			capture_evt_r <= 1'b0;
		end else begin
			wrap_evt_r <= ovf | unf;
			capture_evt_r <= cap_evt;
		end
	end

endmodule : general_purpose_timer_unit

//--- gpt_chk.sv
`timescale 1ns/1ps

module gpt_chk #(
	parameter int TMR_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic [timer_unit_pkg::NUM_TMR-1:0] timer_gate_clock_input,
	input wire logic [timer_unit_pkg::NUM_TMR-1:0] timer_direction_input,
	input wire logic capture_trigger_input,
	// Setup and software loads
	input timer_unit_pkg::timer_cfg_s tmr_cfg [timer_unit_pkg::NUM_TMR],
	input timer_unit_pkg::aux_cfg_s aux_cfg [2],
	input timer_unit_pkg::mod2_cfg_s mod2_cfg,
	input wire logic [timer_unit_pkg::NUM_TMR-1:0] tmr_wr,
	input wire logic capture_reload_reg_wr,
	input wire logic [TMR_W-1:0] wr_data,
	// Observed state
	input logic [TMR_W-1:0] tmr_val [timer_unit_pkg::NUM_TMR],
	input wire logic [TMR_W-1:0] capture_reload_reg,
	input wire logic [timer_unit_pkg::NUM_TMR-1:0] wrap_evt_r,
	input wire logic capture_evt_r,
	input wire logic core_toggle_latch,
	input wire logic core_toggle_output_pin,
	input wire logic toggle_two_latch
);
	// One clock domain, raw reset as the disable
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Capture into the module-two register that software did not overwrite
	sequence s_cap_two;
		capture_evt_r && !$past(capture_reload_reg_wr);
	endsequence
	// Gate held shut long enough to pass the synchroniser
	sequence s_gate_shut;
		(timer_gate_clock_input[0] != tmr_cfg[0].gate_hi) [*6];
	endsequence

	AST_PIN_MIRROR: assert property (core_toggle_output_pin == core_toggle_latch)
		else $error("toggle pin differs from latch");
	// Latch and wrap strobe both move at the wrap edge, so they are seen together
	AST_LATCH_ONE: assert property ($changed(core_toggle_latch) |-> wrap_evt_r[1])
		else $error("core one latch moved without a wrap");
	AST_LATCH_TWO: assert property (wrap_evt_r[4] |->
		toggle_two_latch != $past(toggle_two_latch))
		else $error("core two wrap left latch unchanged");
	AST_WRAP_VAL: assert property (wrap_evt_r[1] && !$past(tmr_wr[1]) &&
		tmr_cfg[1].mode == timer_unit_pkg::MODE_TIMER && !tmr_cfg[1].ext_dir &&
		aux_cfg[0].fn == timer_unit_pkg::AUX_COUNT && aux_cfg[1].fn == timer_unit_pkg::AUX_COUNT
		|-> tmr_val[1] == (tmr_cfg[1].down ? 16'hFFFF : 16'h0000))
		else $error("core one wrap value wrong");
	// The reload and the capture take the value that stood just before the strobe edge
	AST_RELOAD_TWO: assert property (wrap_evt_r[4] && mod2_cfg.rel_en && !$past(tmr_wr[4]) &&
		tmr_cfg[4].mode == timer_unit_pkg::MODE_TIMER |-> tmr_val[4] == $past(capture_reload_reg))
		else $error("core two not reloaded");
	AST_CAP_TWO: assert property (s_cap_two |-> capture_reload_reg == $past(tmr_val[3]))
		else $error("capture register missed aux c");
	AST_CLR_C: assert property (s_cap_two ##0 (mod2_cfg.clr_c && !tmr_cfg[3].run &&
		!$past(tmr_wr[3])) |-> tmr_val[3] == 16'h0000)
		else $error("aux c not cleared");
	AST_CAP_ONE: assert property (aux_cfg[0].fn == timer_unit_pkg::AUX_CAPTURE &&
		$changed(tmr_val[0]) && !$past(tmr_wr[0]) |-> tmr_val[0] == $past(tmr_val[1]))
		else $error("aux a changed other than by capture");
	AST_STEP_ONE: assert property (tmr_cfg[1].mode == timer_unit_pkg::MODE_TIMER &&
		!tmr_cfg[1].ext_dir && aux_cfg[0].fn == timer_unit_pkg::AUX_COUNT &&
		aux_cfg[1].fn == timer_unit_pkg::AUX_COUNT && $changed(tmr_val[1]) && !$past(tmr_wr[1])
		|-> tmr_val[1] == $past(tmr_val[1]) + (tmr_cfg[1].down ? 16'hFFFF : 16'h0001))
		else $error("core one step not one count");
	AST_GATED: assert property (s_gate_shut ##0 (tmr_cfg[0].mode == timer_unit_pkg::MODE_GATED &&
		aux_cfg[0].fn == timer_unit_pkg::AUX_COUNT) |=> $stable(tmr_val[0]) || $past(tmr_wr[0]))
		else $error("aux a counted with gate shut");
endmodule : gpt_chk

//--- pin_model.sv
`timescale 1ns/1ps

module pin_model (
	// Clock
	input wire logic clk,
	// Pins toward the timer unit
	output logic [timer_unit_pkg::NUM_TMR-1:0] gate,
	output logic [timer_unit_pkg::NUM_TMR-1:0] dir,
	output logic cap
);
	// All pins idle low at time zero
	initial begin
		gate = '0;
		dir = '0;
		cap = 1'b0;
	end

	// spaced changes
	// Slow sensor: each change is held 4 clocks so the synchroniser sees it
	task automatic flip(input int p);
		@(posedge clk);
		if (p < timer_unit_pkg::IX_DIR0) begin
			gate[p] <= ~gate[p];
		end else if (p < timer_unit_pkg::IX_CAP) begin
			dir[p - timer_unit_pkg::IX_DIR0] <= ~dir[p - timer_unit_pkg::IX_DIR0];
		end else begin
			cap <= ~cap;
		end
		repeat (4) @(posedge clk);
	endtask : flip

	// quadrature order
	// One gray step; A leads B when moving up, never both at once
	task automatic quad(input int t, input bit up);
		if (up == (gate[t] == dir[t])) begin
			flip(t);
		end else begin
			flip(t + timer_unit_pkg::IX_DIR0);
		end
	endtask : quad
endmodule : pin_model

//--- tb_top.sv
`timescale 1ns/1ps

module tb_top;
	// Clock, reset and pins
	logic clk;
	logic rst_n;
	logic [4:0] gpin;
	logic [4:0] dpin;
	logic cpin;
	// Setup and loads
	timer_unit_pkg::timer_cfg_s tc [5];
	timer_unit_pkg::aux_cfg_s ac [2];
	timer_unit_pkg::mod2_cfg_s m2;
	logic [4:0] wr;
	logic cwr;
	logic [15:0] wd;
	// Observed outputs
	logic [15:0] val [5];
	logic [15:0] crr;
	logic [4:0] wev;
	logic cev;
	logic tl;
	logic tl_pin;
	logic tl2;
	// Bench state
	int miscompares;
	int n_tests;
	int cyc;
	int n;
	int k;
	logic seen;
	logic b;
	logic [31:0] rng;
	logic [15:0] v;
	// Setup built up field by field before one drive
	timer_unit_pkg::timer_cfg_s cfg;

	pin_model pins (.clk(clk), .gate(gpin), .dir(dpin), .cap(cpin));

	general_purpose_timer_unit dut (.clk(clk), .rst_n(rst_n), .timer_gate_clock_input(gpin),
		.timer_direction_input(dpin), .capture_trigger_input(cpin), .tmr_cfg(tc), .aux_cfg(ac),
		.mod2_cfg(m2), .tmr_wr(wr), .capture_reload_reg_wr(cwr), .wr_data(wd), .tmr_val(val),
		.capture_reload_reg(crr), .wrap_evt_r(wev), .capture_evt_r(cev),
		.core_toggle_latch(tl), .core_toggle_output_pin(tl_pin), .toggle_two_latch(tl2));

	// Free-running clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Cut a hang short; run needs about a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			close_out();
		end
	end

	// Remember any module-two capture pulse
	always @(posedge clk) begin
		if (cev === 1'b1) seen <= 1'b1;
	end

	// Repeatable xorshift source
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	// Running timer setup with gate active high and no direction pin
	function automatic timer_unit_pkg::timer_cfg_s mk(input timer_unit_pkg::mode_e m,
		input logic [2:0] p, input logic dn, input logic [1:0] es);
		return '{1'b1, m, p, dn, 1'b0, 1'b1, es, 1'b0};
	endfunction : mk

	// Counter result: both edges count twice per pulse
	function automatic logic [15:0] exp_cnt(input logic [15:0] s, input int es, input int k,
		input logic dn);
		int st;
		st = (es == 3) ? 2 * k : k;
		return dn ? s - 16'(st) : s + 16'(st);
	endfunction : exp_cnt

	// Capture source table: pin 0 count, 1 direction, 2 capture pin
	function automatic logic exp_cap(input int s, input int p);
		if (s == 0) return p == 2;
		return (p == 0) ? s[0] : (p == 1) ? s[1] : 1'b0;
	endfunction : exp_cap

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : check

	// Software load; returns at the falling edge so values have settled
	task automatic load(input int i, input logic [15:0] d);
		@(posedge clk);
		wr[i] <= 1'b1;
		wd <= d;
		@(posedge clk);
		wr[i] <= 1'b0;
		@(negedge clk);
	endtask : load

	// Count edges until a timer changes, bounded
	task automatic wait_chg(input int i, output int c);
		logic [15:0] o;
		o = val[i];
		c = 0;
		while (val[i] === o && c < 2000) begin
			@(posedge clk);
			c++;
		end
	endtask : wait_chg

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out

	initial begin
		rst_n = 1'b0;
		rng = 32'h00000052;
		foreach (tc[i]) tc[i] = '0;
		ac[0] = '0;
		ac[1] = '0;
		m2 = '0;
		wr = '0;
		cwr = 1'b0;
		wd = '0;
		cyc = 0;
		seen = 1'b0;
		miscompares = 0;
		n_tests = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (val[i]) check("reset value", val[i], 16'h0000);
		// Prescaled tick spacing on core two
		k = xs() % 3;
		@(posedge clk);
		tc[4] <= mk(timer_unit_pkg::MODE_TIMER, k[2:0], 1'b0, 2'h1);
		wait_chg(4, n);
		wait_chg(4, n);
		check("tick spacing", n, 8 << k);
		tc[4] <= '0;
		// Counter mode on aux b, edge selects in turn and random direction
		for (int t = 0; t < 4; t++) begin
			v = xs();
			k = 1 + v % 4;
			@(posedge clk);
			cfg = mk(timer_unit_pkg::MODE_COUNTER, 3'h0, v[4], 2'((t % 3) + 1));
			cfg.ext_dir = v[5];
			tc[2] <= cfg;
			if (dpin[2] != v[6]) pins.flip(timer_unit_pkg::IX_DIR0 + 2);
			load(2, 16'h0100);
			repeat (2 * k) pins.flip(2);
			repeat (4) @(posedge clk);
			check("counter", val[2], exp_cnt(16'h0100, t % 3 + 1, k, v[4] ^ (v[5] & v[6])));
		end
		tc[2] <= '0;
		// Gated mode on aux a
		@(posedge clk);
		tc[0] <= mk(timer_unit_pkg::MODE_GATED, 3'h0, 1'b0, 2'h1);
		load(0, 16'h0000);
		repeat (80) @(posedge clk);
		check("gate shut", val[0], 16'h0000);
		pins.flip(0);
		repeat (80) @(posedge clk);
		check("gate open", val[0] >= 9 && val[0] <= 11, 1'b1);
		pins.flip(0);
		tc[0] <= '0;
		// Wrap up then down on core one, latch and pin follow
		for (int d = 0; d < 2; d++) begin
			@(posedge clk);
			tc[1] <= mk(timer_unit_pkg::MODE_TIMER, 3'h0, d[0], 2'h1);
			b = tl;
			load(1, d ? 16'h0000 : 16'hFFFF);
			wait_chg(1, n);
			// Logical not keeps the expectation one bit wide
			check("wrap", val[1], d ? 16'hFFFF : 16'h0000);
			check("latch", tl, !b);
			check("latch pin", tl_pin, !b);
		end
		// Aux a as capture register stops counting and takes core one on its pin
		v = xs();
		@(posedge clk);
		tc[1] <= '0;
		tc[0] <= mk(timer_unit_pkg::MODE_TIMER, 3'h0, 1'b0, 2'h1);
		ac[0] <= '{timer_unit_pkg::AUX_CAPTURE, 2'h1, 2'h0};
		load(1, v);
		load(0, 16'h0000);
		repeat (40) @(posedge clk);
		check("capture stopped", val[0], 16'h0000);
		pins.flip(0);
		repeat (2) @(posedge clk);
		check("capture", val[0], v);
		pins.flip(0);
		tc[0] <= '0;
		ac[0] <= '0;
		// Incremental decoding on core one
		@(posedge clk);
		tc[1] <= mk(timer_unit_pkg::MODE_INCR, 3'h0, 1'b0, 2'h3);
		load(1, 16'd100);
		repeat (4) pins.quad(1, 1'b1);
		repeat (4) @(posedge clk);
		check("incr up", val[1], 16'h0068);
		repeat (4) pins.quad(1, 1'b0);
		repeat (4) @(posedge clk);
		check("incr back", val[1], 16'h0064);
		tc[1] <= '0;
		// Module-two capture sources with clear of aux c
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 3; p++) begin
				v = xs();
				@(posedge clk);
				m2 <= '{1'b0, s[1:0], 2'h3, 1'b1};
				load(3, v);
				seen = 1'b0;
				pins.flip(p == 0 ? 1 : p == 1 ? timer_unit_pkg::IX_DIR0 + 1 : timer_unit_pkg::IX_CAP);
				repeat (4) @(posedge clk);
				check("capture source", seen, exp_cap(s, p));
				check("aux c clear", val[3], seen ? 16'h0000 : v);
				if (seen) check("capture value", crr, v);
			end
		end
		// Core two wrap reloads from the capture register and toggles its latch
		v = xs();
		@(posedge clk);
		m2 <= '{1'b1, 2'h0, 2'h0, 1'b0};
		cwr <= 1'b1;
		wd <= v;
		@(posedge clk);
		cwr <= 1'b0;
		tc[4] <= mk(timer_unit_pkg::MODE_TIMER, 3'h0, 1'b0, 2'h1);
		// Aux c counts moves of latch two
		cfg = mk(timer_unit_pkg::MODE_COUNTER, 3'h0, 1'b0, 2'h1);
		cfg.alt_src = 1'b1;
		tc[3] <= cfg;
		k = val[3];
		b = tl2;
		load(4, 16'hFFFF);
		wait_chg(4, n);
		check("reload two", val[4], v);
		check("latch two", tl2, !b);
		check("aux c on latch two", val[3], 16'(k + 1));
		// Aux a and aux b reload core one on opposite latch moves
		v = xs();
		@(posedge clk);
		ac[0] <= '{timer_unit_pkg::AUX_RELOAD, 2'h0, timer_unit_pkg::RLD_TL_RISE};
		ac[1] <= '{timer_unit_pkg::AUX_RELOAD, 2'h0, timer_unit_pkg::RLD_TL_FALL};
		tc[1] <= mk(timer_unit_pkg::MODE_TIMER, 3'h0, 1'b0, 2'h1);
		load(0, {12'hFFF, v[3:0]});
		load(2, {12'hFFF, v[7:4]});
		load(1, 16'hFFFF);
		for (int j = 0; j < 4; j++) begin
			b = tl;
			n = 0;
			// Bounded wait for the next latch move
			while (tl === b && n < 200) begin
				@(posedge clk);
				n++;
			end
			check("pwm reload", val[1], b ? {12'hFFF, v[7:4]} : {12'hFFF, v[3:0]});
		end
		close_out();
	end
endmodule : tb_top

bind general_purpose_timer_unit gpt_chk #(.TMR_W(TMR_W)) chk (.clk(clk), .rst_n(rst_n),
	.timer_gate_clock_input(timer_gate_clock_input), .timer_direction_input(timer_direction_input),
	.capture_trigger_input(capture_trigger_input), .tmr_cfg(tmr_cfg), .aux_cfg(aux_cfg),
	.mod2_cfg(mod2_cfg), .tmr_wr(tmr_wr), .capture_reload_reg_wr(capture_reload_reg_wr), .wr_data(wr_data),
	.tmr_val(tmr_val), .capture_reload_reg(capture_reload_reg), .wrap_evt_r(wrap_evt_r),
	.capture_evt_r(capture_evt_r), .core_toggle_latch(core_toggle_latch),
	.core_toggle_output_pin(core_toggle_output_pin), .toggle_two_latch(toggle_two_latch));

//--- timer_cell.sv
`timescale 1ns/1ps

module timer_cell #(
	parameter int W = 16
) (
	// Clock and synchronised reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration
	input timer_unit_pkg::timer_cfg_s cfg,
	// Count sources
	input wire logic pre_tick,
	input wire logic in_lvl,
	input wire logic in_rise,
	input wire logic in_fall,
	input wire logic eud_lvl,
	input wire logic eud_chg,
	input wire logic alt_evt,
	// Control from the unit
	input wire logic stop,
	input wire logic ld,
	input wire logic [W-1:0] ld_val,
	// State and wrap events
	output logic [W-1:0] cnt_r,
	output logic ovf,
	output logic unf
);

	// Count step of this cycle
	logic step;
	// Count down this cycle
	logic down;
	// Any edge of the gate/clock pin
	logic in_chg;

	// Width below two leaves no room for a wrap
	if (W < 2) begin : g_chk
		$error("timer_cell: W must be at least 2");
	end

	assign in_chg = in_rise | in_fall;

	// Step and direction per mode
	always_comb begin
		step = 1'b0;
		down = cfg.down ^ (cfg.ext_dir & eud_lvl);
		case (cfg.mode)
			timer_unit_pkg::MODE_TIMER: begin
				step = pre_tick;
			end
			timer_unit_pkg::MODE_GATED: begin
				step = pre_tick & (in_lvl == cfg.gate_hi);
			end
			timer_unit_pkg::MODE_COUNTER: begin
				if (cfg.alt_src) begin
					step = alt_evt;
				end else begin
					step = timer_unit_pkg::edge_hit(cfg.edge_sel, in_rise, in_fall);
				end
			end
			timer_unit_pkg::MODE_INCR: begin
				// Both tracks moving at once is a glitch and is not counted
				step = in_chg ^ eud_chg;
				down = in_chg ? ~(in_lvl ^ eud_lvl) : (in_lvl ^ eud_lvl);
			end
			default: begin
				step = 1'b0;
			end
		endcase
		step = step & cfg.run & ~stop;
	end

	assign ovf = step & ~down & (&cnt_r);
	assign unf = step & down & ~(|cnt_r);

	// Counter register; a load beats a step in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (ld) begin
			cnt_r <= ld_val;
		end else if (step) begin
			cnt_r <= down ? cnt_r - 1'b1 : cnt_r + 1'b1;
		end
	end

endmodule : timer_cell

//--- timer_unit_pkg.sv
package timer_unit_pkg;

	// Width of every timer and of the capture/reload register
	localparam int TMR_W = 16;
	// Five timers: three in module one, two in module two
	localparam int NUM_TMR = 5;
	// Timer slots: aux a, core one, aux b (module one); aux c, core two (module two)
	localparam int IX_A = 0;
	localparam int IX_CORE1 = 1;
	localparam int IX_B = 2;
	localparam int IX_C = 3;
	localparam int IX_CORE2 = 4;
	// Pin slots above the timer pins: direction pins, then the capture pin
	localparam int IX_DIR0 = NUM_TMR;
	localparam int IX_CAP = 2 * NUM_TMR;
	localparam int NUM_PIN = 2 * NUM_TMR + 1;

	// Finest step is 16 state-time units; one clock is two units
	localparam int RES_STU = 16;
	localparam int STU_PER_CLK = 2;
	localparam int PRESC_BASE = RES_STU / STU_PER_CLK;
	// Prescaler select width and divider width (base shifted by up to 7)
	localparam int PSEL_W = 3;
	localparam int PRESC_W = 10;

	// Basic operating modes of a timer
	typedef enum logic [1:0] {
		MODE_TIMER = 2'h0,
		MODE_GATED = 2'h1,
		MODE_COUNTER = 2'h2,
		MODE_INCR = 2'h3
	} mode_e;

	// Function of an auxiliary timer of module one
	typedef enum logic [1:0] {
		AUX_COUNT = 2'h0,
		AUX_CAPTURE = 2'h1,
		AUX_RELOAD = 2'h2
	} aux_fn_e;

	// Edge select field: bit 0 rising, bit 1 falling
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;
	// Reload trigger of the core timer
	localparam logic [1:0] RLD_PIN = 2'h0;
	localparam logic [1:0] RLD_TL_RISE = 2'h1;
	localparam logic [1:0] RLD_TL_FALL = 2'h2;
	localparam logic [1:0] RLD_TL_ANY = 2'h3;
	// Trigger of the module-two capture: bit 0 core count pin, bit 1 core direction pin
	localparam logic [1:0] CAP_SRC_PIN = 2'h0;

	// Per-timer configuration
	typedef struct packed {
		logic run;
		mode_e mode;
		logic [PSEL_W-1:0] presc;
		logic down;
		logic ext_dir;
		logic gate_hi;
		logic [1:0] edge_sel;
		logic alt_src;
	} timer_cfg_s;

	// Capture/reload setup of aux a or aux b
	typedef struct packed {
		aux_fn_e fn;
		logic [1:0] edge_sel;
		logic [1:0] rld_src;
	} aux_cfg_s;

	// Module-two capture/reload setup
	typedef struct packed {
		logic rel_en;
		logic [1:0] cap_src;
		logic [1:0] cap_edge;
		logic clr_c;
	} mod2_cfg_s;

	// Selected edge seen
	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		return (sel[EDGE_RISE_BIT] & rise) | (sel[EDGE_FALL_BIT] & fall);
	endfunction : edge_hit

endpackage : timer_unit_pkg
